// ==== rtl/sbbs_top.sv ====
`timescale 1ns/1ps
// Contract
// - A break seen on the receive line sets the break flag; no interrupt.
// - Break also sets framing error, receive full, and clears ninth bit in 9-bit mode.
// - Break flag clears by status-two read with flag set, then data buffer read.
// - After clearing, new break needs ones on the line then a full break.
// - Reception-active sets on a low in the first sample slot of start search.
// - Reception-active clears on a false start or an idle character.
// - Data buffer read returns received byte, write supplies transmit byte; separate paths.
// - Data buffer contents are untouched by any reset.
// - LIN receive option needs 11 or 12 low bits per length selector.
// - LIN transmit option makes breaks 11 or 12 bit times per selector.
// - LIN receive length filters zero bytes up to 10.35 bits from breaks.
// - Coarse prescaler codes 00..11 divide by 1, 3, 4, 13.
// - Rate select divides by two to the field value; reset clears it.
// - Integer prescaler code 000 bypasses, else divides by code plus one.
// - Integer prescaler bypass also bypasses the fractional adjust.
// - Insertion field adds N extra clocks per 32 prescaler outputs.
// - Rate and prescaler registers set one rate for receiver and transmitter.
// - Baud equals clock over 64 times coarse, rate and integer-plus-fraction.
module sbbs_top
  import sbbs_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_rxd,
  input wire logic i_char_long,
  input wire logic i_send_break,
  input wire logic i_rx_load,
  input wire logic [7:0] i_rx_byte,
  output logic o_framing_error_set,
  output logic o_receive_full_set,
  output logic o_ninth_bit_clear,
  output logic o_tx_load,
  output logic [7:0] o_tx_byte,
  output logic o_txd_break_low,
  output logic o_break_busy,
  output logic o_rt_tick
);
  import sbbs_pkg::*;

  // =====================================================================
  // State
  // =====================================================================
  typedef struct packed {
    logic [7:0] rate_sel;
    logic [7:0] prescale;
    logic break_flag;
    logic reception_active_flag;
    logic clear_armed;
    logic line_rearmed;
    logic [7:0] low_slots;
    logic [7:0] high_slots;
    logic idle_reported;
    logic [7:0] rdata;
    logic fe_set;
    logic rf_set;
    logic ninth_clear;
    logic tx_load;
    logic txd_low;
    logic break_busy;
    logic rt_tick;
  } sbbs_top_state_type;

  // Data paths kept apart from the reset state
  typedef struct packed {
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
  } sbbs_top_data_type;

  sbbs_top_state_type st_q, st_d;
  sbbs_top_data_type dat_q, dat_d;
  sbbs_tick_if tick_bus ();

  logic lin_rx;
  logic lin_tx;
  logic [3:0] rx_break_bits;
  logic [3:0] idle_bits;
  logic [7:0] rx_break_slots;
  logic [7:0] idle_slots;
  logic rd_status;
  logic rd_data;
  logic wr_data;
  logic slot;
  logic start_seen;
  logic false_start;
  logic idle_seen;
  logic break_seen;

  // =====================================================================
  // Submodules
  // =====================================================================
  // One tick source feeds both directions, so rates always match
  sbbs_baud_gen u_baud (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_coarse_sel(st_q.rate_sel[POS_COARSE +: 2]),
    .i_rate_sel(st_q.rate_sel[POS_RATE +: 3]),
    .i_int_pre(st_q.prescale[POS_INT_PRE +: 3]),
    .i_insert(st_q.prescale[POS_INSERT +: 5]),
    .tick(tick_bus.gen)
  );

  sbbs_break_gen u_break (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .tick(tick_bus.txb)
  );

  // =====================================================================
  // Option decode
  // =====================================================================
  assign lin_rx = st_q.rate_sel[BIT_LIN_RX];
  assign lin_tx = st_q.rate_sel[BIT_LIN_TX];
  assign slot = tick_bus.rt_tick;

  // Break lengths; without LIN options the plain lengths apply
  always_comb begin
    if (lin_rx) begin
      rx_break_bits = i_char_long ? BITS_LIN_LONG : BITS_LIN_SHORT;
    end else begin
      rx_break_bits = i_char_long ? BITS_BREAK_LONG : BITS_BREAK_SHORT;
    end
    if (lin_tx) begin
      tick_bus.break_bits = i_char_long ? BITS_LIN_LONG : BITS_LIN_SHORT;
    end else begin
      tick_bus.break_bits = i_char_long ? BITS_BREAK_LONG : BITS_BREAK_SHORT;
    end
    idle_bits = i_char_long ? BITS_IDLE_LONG : BITS_IDLE_SHORT;
  end

  assign tick_bus.send_break = i_send_break;
  assign rx_break_slots = {rx_break_bits, 4'h0};
  assign idle_slots = {idle_bits, 4'h0};

  // =====================================================================
  // Register port strobes
  // =====================================================================
  assign rd_status = i_rd && (i_addr == ADDR_STATUS_TWO);
  assign rd_data = i_rd && (i_addr == ADDR_DATA_BUF);
  assign wr_data = i_wr && (i_addr == ADDR_DATA_BUF);

  // =====================================================================
  // Receive line watcher
  // =====================================================================
  // First low slot while searching marks a start bit
  assign start_seen = slot && !i_rxd && (st_q.low_slots == 8'h0);
  // Line back high before mid start bit means a false start
  assign false_start = slot && i_rxd && (st_q.low_slots != 8'h0)
    && (st_q.low_slots <= FALSE_START_SLOTS);
  // A full idle character of ones, reported once per idle stretch
  assign idle_seen = slot && i_rxd && !st_q.idle_reported
    && (st_q.high_slots + 8'h1 >= idle_slots);
  // Low for a whole break length, only once the line has recovered
  assign break_seen = slot && !i_rxd && st_q.line_rearmed
    && (st_q.low_slots + 8'h1 >= rx_break_slots);

  // =====================================================================
  // Next state
  // =====================================================================
  always_comb begin
    st_d = st_q;

    // Slot counters saturate so long breaks do not wrap
    if (slot) begin
      if (i_rxd) begin
        st_d.low_slots = 8'h0;
        st_d.line_rearmed = 1'b1;
        if (st_q.high_slots != 8'hff) begin
          st_d.high_slots = st_q.high_slots + 8'h1;
        end
        if (idle_seen) begin
          st_d.idle_reported = 1'b1;
        end
      end else begin
        st_d.high_slots = 8'h0;
        st_d.idle_reported = 1'b0;
        if (st_q.low_slots != 8'hff) begin
          st_d.low_slots = st_q.low_slots + 8'h1;
        end
      end
    end
    if (break_seen) begin
      st_d.line_rearmed = 1'b0;
    end

    // Reception active: set on start slot, cleared on false start or idle
    if (start_seen) begin
      st_d.reception_active_flag = 1'b1;
    end else if (false_start || idle_seen) begin
      st_d.reception_active_flag = 1'b0;
    end

    // Break flag clear sequence: status read with flag set, then data read
    if (rd_status && st_q.break_flag) begin
      st_d.clear_armed = 1'b1;
    end
    if (rd_data && st_q.clear_armed) begin
      st_d.break_flag = 1'b0;
      st_d.clear_armed = 1'b0;
    end
    // A new break in the clearing cycle is kept
    if (break_seen) begin
      st_d.break_flag = 1'b1;
      st_d.clear_armed = 1'b0;
    end

    // Side effects of a break on the other receiver flags
    st_d.fe_set = break_seen;
    st_d.rf_set = break_seen;
    st_d.ninth_clear = break_seen && i_char_long;

    // Register writes
    if (i_wr) begin
      if (i_addr == ADDR_RATE_SEL) begin
        st_d.rate_sel = i_wdata;
      end else if (i_addr == ADDR_PRESCALE) begin
        st_d.prescale = i_wdata;
      end
    end
    st_d.tx_load = wr_data;

    // Read data stands only in the cycle after the strobe
    st_d.rdata = 8'h00;
    if (i_rd) begin
      if (i_addr == ADDR_STATUS_TWO) begin
        st_d.rdata[BIT_BREAK_FLAG] = st_q.break_flag;
        st_d.rdata[BIT_RX_ACTIVE] = st_q.reception_active_flag;
      end else if (i_addr == ADDR_DATA_BUF) begin
        st_d.rdata = dat_q.rx_byte;
      end else if (i_addr == ADDR_RATE_SEL) begin
        st_d.rdata = st_q.rate_sel;
      end else if (i_addr == ADDR_PRESCALE) begin
        st_d.rdata = st_q.prescale;
      end else begin
        st_d.rdata = 8'h00;
      end
    end

    // Registered copies of the submodule outputs
    st_d.txd_low = tick_bus.txd_low;
    st_d.break_busy = tick_bus.busy;
    st_d.rt_tick = tick_bus.rt_tick;
  end

  // Data buffer paths: receive side loads, transmit side takes writes
  always_comb begin
    dat_d = dat_q;
    if (i_rx_load) begin
      dat_d.rx_byte = i_rx_byte;
    end
    if (wr_data) begin
      dat_d.tx_byte = i_wdata;
    end
  end

  // =====================================================================
  // Registers
  // =====================================================================
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= '0;
      st_q.rate_sel <= RST_RATE_SEL;
      st_q.prescale <= RST_PRESCALE;
    end else begin
      st_q <= st_d;
    end
  end

  // No reset: buffer contents survive every reset
  always_ff @(posedge i_core_clk) begin
    dat_q <= dat_d;
  end

  // =====================================================================
  // Outputs
  // =====================================================================
  assign o_rdata = st_q.rdata;
  assign o_framing_error_set = st_q.fe_set;
  assign o_receive_full_set = st_q.rf_set;
  assign o_ninth_bit_clear = st_q.ninth_clear;
  assign o_tx_load = st_q.tx_load;
  assign o_tx_byte = dat_q.tx_byte;
  assign o_txd_break_low = st_q.txd_low;
  assign o_break_busy = st_q.break_busy;
  assign o_rt_tick = st_q.rt_tick;
endmodule // sbbs_top

// ==== inc/sbbs_pkg.sv ====
// =====================================================================
// Shared constants for the serial baud, break and status block
// =====================================================================
package sbbs_pkg;

  // =====================================================================
  // Register map (byte addresses on the plain register port)
  // =====================================================================
  localparam logic [2:0] ADDR_STATUS_TWO = 3'h0;
  localparam logic [2:0] ADDR_DATA_BUF = 3'h1;
  localparam logic [2:0] ADDR_RATE_SEL = 3'h2;
  localparam logic [2:0] ADDR_PRESCALE = 3'h3;

  // =====================================================================
  // Field positions
  // =====================================================================
  localparam int BIT_BREAK_FLAG = 1;
  localparam int BIT_RX_ACTIVE = 0;
  localparam int BIT_LIN_TX = 7;
  localparam int BIT_LIN_RX = 6;
  localparam int POS_COARSE = 4;
  localparam int POS_RATE = 0;
  localparam int POS_INT_PRE = 5;
  localparam int POS_INSERT = 0;

  // =====================================================================
  // Reset values
  // =====================================================================
  localparam logic [7:0] RST_RATE_SEL = 8'h00;
  localparam logic [7:0] RST_PRESCALE = 8'h00;

  // =====================================================================
  // Timing counts, in receiver sample slots and bit times
  // =====================================================================
  localparam logic [7:0] SLOTS_PER_BIT = 8'h10;
  localparam logic [7:0] FALSE_START_SLOTS = 8'h07;
  localparam logic [3:0] BITS_BREAK_SHORT = 4'ha;
  localparam logic [3:0] BITS_BREAK_LONG = 4'hb;
  localparam logic [3:0] BITS_LIN_SHORT = 4'hb;
  localparam logic [3:0] BITS_LIN_LONG = 4'hc;
  localparam logic [3:0] BITS_IDLE_SHORT = 4'ha;
  localparam logic [3:0] BITS_IDLE_LONG = 4'hb;
  localparam logic [2:0] SLOT_PRE_DIV = 3'h4;
  localparam logic [4:0] FRAC_FRAME = 5'h1f;

  // Transmit break sequencer states
  typedef enum logic [1:0] {
    TXB_IDLE = 2'b00,
    TXB_LOW = 2'b01,
    TXB_MARK = 2'b10
  } sbbs_txb_state_type;

endpackage

// ==== inc/sbbs_tick_if.sv ====
`timescale 1ns/1ps
// =====================================================================
// Sample-slot tick and break length settings shared inside the block
// =====================================================================
interface sbbs_tick_if;
  logic rt_tick;
  logic [3:0] break_bits;
  logic send_break;
  logic txd_low;
  logic busy;

  modport gen (output rt_tick);
  modport txb (input rt_tick, input break_bits, input send_break, output txd_low, output busy);
  modport top (input rt_tick, output break_bits, output send_break, input txd_low, input busy);
endinterface

// ==== rtl/sbbs_baud_gen.sv ====
`timescale 1ns/1ps
// =====================================================================
// Baud generator: integer prescaler with spread clock insertion,
// then coarse, power-of-two and slot dividers
// =====================================================================
module sbbs_baud_gen
  import sbbs_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [1:0] i_coarse_sel,
  input wire logic [2:0] i_rate_sel,
  input wire logic [2:0] i_int_pre,
  input wire logic [4:0] i_insert,
  sbbs_tick_if.gen tick
);
  typedef struct packed {
    logic [3:0] pre_cnt;
    logic [4:0] frac_acc;
    logic extra;
    logic [12:0] div_cnt;
    logic rt_tick;
  } sbbs_bg_state_type;

  sbbs_bg_state_type st_q, st_d;
  logic [3:0] coarse_div;
  logic [12:0] div_last;
  logic pre_tick;
  logic [5:0] acc_sum;

  // Coarse divisor 1, 3, 4 or 13
  always_comb begin
    case (i_coarse_sel)
      2'b00: coarse_div = 4'h1;
      2'b01: coarse_div = 4'h3;
      2'b10: coarse_div = 4'h4;
      default: coarse_div = 4'hd;
    endcase
  end

  // One combined divider: coarse x 2^rate x slot predivide
  assign div_last = (13'(coarse_div) * 13'(SLOT_PRE_DIV) << i_rate_sel) - 13'h1;

  // Next state of the prescaler chain
  always_comb begin
    st_d = st_q;
    acc_sum = {1'b0, st_q.frac_acc} + {1'b0, i_insert};
    pre_tick = 1'b0;
    if (i_int_pre == 3'h0) begin
      // Bypass skips the fine adjust too
      pre_tick = 1'b1;
      st_d.pre_cnt = 4'h0;
    end else if (st_q.pre_cnt >= {1'b0, i_int_pre} + {3'h0, st_q.extra}) begin
      pre_tick = 1'b1;
      st_d.pre_cnt = 4'h0;
      // Carry-out spreads N extra clocks evenly over 32 outputs
      st_d.frac_acc = acc_sum[4:0];
      st_d.extra = acc_sum[5];
    end else begin
      st_d.pre_cnt = st_q.pre_cnt + 4'h1;
    end
    st_d.rt_tick = 1'b0;
    if (pre_tick) begin
      if (st_q.div_cnt >= div_last) begin
        st_d.div_cnt = 13'h0;
        st_d.rt_tick = 1'b1;
      end else begin
        st_d.div_cnt = st_q.div_cnt + 13'h1;
      end
    end
  end

  // State register
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick.rt_tick = st_q.rt_tick;
endmodule // sbbs_baud_gen

// ==== rtl/sbbs_break_gen.sv ====
`timescale 1ns/1ps
// =====================================================================
// Transmit break sequencer: a run of zeros, then one mark bit
// =====================================================================
module sbbs_break_gen
  import sbbs_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  sbbs_tick_if.txb tick
);
  typedef struct packed {
    sbbs_txb_state_type state;
    logic [7:0] slot_cnt;
    logic txd_low;
  } sbbs_bk_state_type;

  sbbs_bk_state_type st_q, st_d;
  logic [7:0] low_slots;

  assign low_slots = {tick.break_bits, 4'h0};

  // Sequencer; a held request chains breaks with no mark between
  always_comb begin
    st_d = st_q;
    case (st_q.state)
      TXB_IDLE: begin
        if (tick.send_break && tick.rt_tick) begin
          st_d.state = TXB_LOW;
          st_d.slot_cnt = 8'h1;
          st_d.txd_low = 1'b1;
        end
      end
      TXB_LOW: begin
        if (tick.rt_tick) begin
          if (st_q.slot_cnt >= low_slots) begin
            st_d.slot_cnt = 8'h1;
            if (!tick.send_break) begin
              st_d.state = TXB_MARK;
              st_d.txd_low = 1'b0;
            end
          end else begin
            st_d.slot_cnt = st_q.slot_cnt + 8'h1;
          end
        end
      end
      TXB_MARK: begin
        if (tick.rt_tick) begin
          if (st_q.slot_cnt >= SLOTS_PER_BIT) begin
            st_d.state = TXB_IDLE;
          end else begin
            st_d.slot_cnt = st_q.slot_cnt + 8'h1;
          end
        end
      end
      default: st_d = '0;
    endcase
  end

  // State register
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick.txd_low = st_q.txd_low;
  assign tick.busy = (st_q.state != TXB_IDLE);
endmodule // sbbs_break_gen

// ==== dv/sbbs_top_chk.sv ====
`timescale 1ns/1ps
// =====================================================================
// Port-level checker for the baud, break and status block
// =====================================================================
module sbbs_top_chk
  import sbbs_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_rxd,
  input wire logic i_char_long,
  input wire logic i_rx_load,
  input wire logic o_framing_error_set,
  input wire logic o_receive_full_set,
  input wire logic o_ninth_bit_clear,
  input wire logic o_tx_load,
  input wire logic [7:0] o_tx_byte,
  input wire logic o_txd_break_low,
  input wire logic o_break_busy,
  input wire logic o_rt_tick
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);

  // =====================================================================
  // Register port and data buffer
  // =====================================================================
  a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read slot");
  a_status_pad: assert property ($past(i_rd) && $past(i_addr) == ADDR_STATUS_TWO |-> o_rdata[7:2] == 6'h00)
    else $error("status two spare bits not zero");
  a_tx_load_follows: assert property (i_wr && i_addr == ADDR_DATA_BUF |=> o_tx_load && o_tx_byte == $past(i_wdata))
    else $error("transmit byte not loaded");
  a_tx_load_cause: assert property (o_tx_load |-> $past(i_wr) && $past(i_addr) == ADDR_DATA_BUF)
    else $error("transmit load without write");
  // Receive traffic must never leak into the transmit path
  a_tx_path_apart: assert property ((i_rd || i_rx_load) && !i_wr |=> $stable(o_tx_byte))
    else $error("transmit byte moved on receive access");

  // =====================================================================
  // Break detect and generate
  // =====================================================================
  a_break_pair: assert property ((o_framing_error_set || o_ninth_bit_clear) |->
    o_framing_error_set && o_receive_full_set && o_ninth_bit_clear == i_char_long)
    else $error("break side flags wrong");
  a_break_on_low: assert property (o_framing_error_set |-> !i_rxd && !$past(i_rxd, 4))
    else $error("break reported with line high");
  a_break_once: assert property (o_framing_error_set |=> !o_framing_error_set [*8])
    else $error("break reported twice");
  a_gen_low_run: assert property ($rose(o_txd_break_low) |=> (o_txd_break_low && o_break_busy) [*8])
    else $error("generated break too short");
  a_tick_spacing: assert property (o_rt_tick |=> !o_rt_tick [*3])
    else $error("sample ticks closer than four clocks");

  // Main scenarios reached
  c_break_long: cover property (o_framing_error_set && o_ninth_bit_clear);
  c_gen_break: cover property ($rose(o_txd_break_low));
  c_tx_load: cover property (o_tx_load);
endmodule // sbbs_top_chk

bind sbbs_top sbbs_top_chk sbbs_top_chk_inst (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_rxd(i_rxd), .i_char_long(i_char_long), .i_rx_load(i_rx_load),
  .o_framing_error_set(o_framing_error_set), .o_receive_full_set(o_receive_full_set),
  .o_ninth_bit_clear(o_ninth_bit_clear), .o_tx_load(o_tx_load), .o_tx_byte(o_tx_byte),
  .o_txd_break_low(o_txd_break_low), .o_break_busy(o_break_busy), .o_rt_tick(o_rt_tick));

// ==== dv/sbbs_remote_node.sv ====
`timescale 1ns/1ps
// =====================================================================
// Remote node: holds the line dominant for a number of sample slots
// =====================================================================
module sbbs_remote_node (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_tick,
  input wire logic i_go,
  input wire logic [9:0] i_low_slots,
  output logic o_rxd,
  output logic o_busy
);
  logic [9:0] left_q;

  // Pulled-up line: mark whenever nothing is left to send
  assign o_rxd = (left_q == 10'h000);
  assign o_busy = (left_q != 10'h000) || i_go;

  // Slot count only, so zero bytes and breaks differ by length alone
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      left_q <= 10'h000;
    end else if (i_go) begin
      left_q <= i_low_slots;
    end else if (i_tick && left_q != 10'h000) begin
      left_q <= left_q - 10'h001;
    end
  end
endmodule // sbbs_remote_node

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
  import sbbs_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_char_long = 1'b0;
  logic i_send_break = 1'b0;
  logic i_rx_load = 1'b0;
  logic [7:0] i_rx_byte = 8'h00;
  logic go = 1'b0;
  logic [9:0] low_slots = 10'h000;
  logic i_rxd, busy, rd_seen, o_framing_error_set, o_receive_full_set, o_ninth_bit_clear;
  logic o_tx_load, o_txd_break_low, o_break_busy, o_rt_tick;
  logic [7:0] o_rdata, o_tx_byte, rxb, txv, pd;
  logic [7:0] rq[$];
  logic [7:0] tq[$];
  logic [7:0] bq[$];
  int error_cnt = 0;
  int comparisons = 0;
  int txl_n = 0;

  always #10 i_core_clk = ~i_core_clk;

  sbbs_top sbbs_top_inst (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(i_rxd), .i_char_long(i_char_long),
    .i_send_break(i_send_break), .i_rx_load(i_rx_load), .i_rx_byte(i_rx_byte),
    .o_framing_error_set(o_framing_error_set), .o_receive_full_set(o_receive_full_set),
    .o_ninth_bit_clear(o_ninth_bit_clear), .o_tx_load(o_tx_load), .o_tx_byte(o_tx_byte),
    .o_txd_break_low(o_txd_break_low), .o_break_busy(o_break_busy), .o_rt_tick(o_rt_tick));
  sbbs_remote_node sbbs_remote_node_inst (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_tick(o_rt_tick),
    .i_go(go), .i_low_slots(low_slots), .o_rxd(i_rxd), .o_busy(busy));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // =====================================================================
  // Monitor: each result at the ports takes the oldest note
  // =====================================================================
  always @(posedge i_core_clk) rd_seen <= i_rd;
  always @(negedge i_core_clk) begin
    if (o_txd_break_low === 1'b1) txl_n++;
    if (rd_seen === 1'b1) chk(o_rdata, rq.size() ? rq.pop_front() : 8'hxx);
    if (o_tx_load === 1'b1) chk(o_tx_byte, tq.size() ? tq.pop_front() : 8'hxx);
    if (o_framing_error_set === 1'b1)
      chk({o_receive_full_set, o_ninth_bit_clear}, bq.size() ? bq.pop_front() : 8'hxx);
  end

  // =====================================================================
  // Bus tasks; the buffer is only read or written whole
  // =====================================================================
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    if (a == ADDR_DATA_BUF) tq.push_back(d);
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    rq.push_back(e);
    @(posedge i_core_clk);
    i_rd <= 1'b0;
  endtask

  task automatic wait_tick;
    @(negedge i_core_clk);
    for (int k = 0; k < 5000 && o_rt_tick !== 1'b1; k++) @(negedge i_core_clk);
  endtask

  // Clocks spanned by eight sample slots
  task automatic baud(input logic [7:0] r, input logic [7:0] p, input logic [15:0] e);
    time t0;
    wr(ADDR_RATE_SEL, r);
    wr(ADDR_PRESCALE, p);
    repeat (3) wait_tick;
    t0 = $time;
    repeat (8) wait_tick;
    chk(16'(($time - t0) / 20), e);
  endtask

  // Dominant stretch of n slots from the remote node
  task automatic rx_case(input logic lin, input logic m, input logic [9:0] n, input logic hit, input logic rev);
    wr(ADDR_RATE_SEL, {1'b0, lin, 6'h00});
    i_char_long <= m;
    go <= 1'b1;
    low_slots <= n;
    if (hit) bq.push_back({7'h00, m} | 8'h02);
    @(posedge i_core_clk);
    go <= 1'b0;
    repeat (40) wait_tick;
    rd(ADDR_STATUS_TWO, {7'h00, n > 10'h028});
    repeat (500) wait_tick;
    if (rev) rd(ADDR_DATA_BUF, rxb);
    rd(ADDR_STATUS_TWO, {6'h00, hit, 1'b0});
    rd(ADDR_DATA_BUF, rxb);
    rd(ADDR_STATUS_TWO, 8'h00);
  endtask

  // Generated break: clocks with the line held low
  task automatic tx_case(input logic [7:0] r, input logic m, input logic [15:0] e);
    wr(ADDR_RATE_SEL, r);
    i_char_long <= m;
    txl_n = 0;
    i_send_break <= 1'b1;
    repeat (20) @(posedge i_core_clk);
    i_send_break <= 1'b0;
    for (int k = 0; k < 3000 && o_break_busy !== 1'b0; k++) @(negedge i_core_clk);
    chk(16'(txl_n), e);
  endtask

  initial begin
    repeat (90000) @(posedge i_core_clk);
    error_cnt++;
    complete_run;
  end

  // =====================================================================
  // Main sequence
  // =====================================================================
  initial begin
    void'($urandom(5367));
    repeat (6) @(posedge i_core_clk);
    @(negedge i_core_clk) i_rstn <= 1'b1;
    wr(ADDR_DATA_BUF, 8'h5a);
    rd(ADDR_RATE_SEL, RST_RATE_SEL);
    rd(ADDR_PRESCALE, RST_PRESCALE);
    rd(3'h5, 8'h00);
    wr(ADDR_STATUS_TWO, 8'hff);
    rd(ADDR_STATUS_TWO, 8'h00);
    rxb = 8'($urandom);
    @(posedge i_core_clk);
    i_rx_load <= 1'b1;
    i_rx_byte <= rxb;
    @(posedge i_core_clk);
    i_rx_load <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      txv = 8'($urandom);
      wr(ADDR_RATE_SEL, txv);
      rd(ADDR_RATE_SEL, txv);
      wr(ADDR_PRESCALE, ~txv);
      rd(ADDR_PRESCALE, ~txv);
      wr(ADDR_DATA_BUF, txv);
      rd(ADDR_DATA_BUF, rxb);
    end
    baud(8'h00, 8'h00, 16'h0020);
    baud(8'h10, 8'h00, 16'h0060);
    baud(8'h20, 8'h00, 16'h0080);
    baud(8'h30, 8'h00, 16'h01a0);
    baud(8'h03, 8'h00, 16'h0100);
    baud(8'h07, 8'h00, 16'h1000);
    baud(8'h00, 8'he0, 16'h0100);
    baud(8'h00, 8'h30, 16'h0050);
    baud(8'h21, 8'h20, 16'h0200);
    for (int i = 0; i < 3; i++) begin
      pd = 8'($urandom_range(7, 1));
      baud(8'h00, {pd[2:0], 5'(i * 13)}, 16'(32 * (pd[2:0] + 1) + i * 13));
    end
    // Bypass entered only while the line is quiet
    baud(8'h00, 8'h1f, 16'h0020);
    for (int i = 0; i < 8; i++) begin
      rx_case(i[0], i[1], {2'h0, 4'ha + i[0] + i[1], 4'h0} + (i[2] ? 10'h008 : 10'h3f8), i[2], 1'b0);
    end
    rx_case(1'b0, 1'b0, 10'h150, 1'b1, 1'b1);
    rx_case(1'b0, 1'b0, 10'h004, 1'b0, 1'b0);
    tx_case(8'h00, 1'b0, 16'h0280);
    tx_case(8'h00, 1'b1, 16'h02c0);
    tx_case(8'h80, 1'b0, 16'h02c0);
    tx_case(8'h80, 1'b1, 16'h0300);
    tx_case(8'h01, 1'b0, 16'h0500);
    chk(16'(bq.size()), 16'h0000);
    @(negedge i_core_clk) i_rstn <= 1'b0;
    repeat (2) @(negedge i_core_clk);
    i_rstn <= 1'b1;
    chk(o_tx_byte, txv);
    rd(ADDR_DATA_BUF, rxb);
    rd(ADDR_RATE_SEL, 8'h00);
    repeat (4) @(posedge i_core_clk);
    complete_run;
  end
endmodule // tb
